/* File: aicsr_cal_chan.sv */
`timescale 1ns/1ps
`include "aicsr_params.svh"
module aicsr_cal_chan (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  cal_req,
    input  wire logic  low_point_sample_request,
    input  wire logic  high_req,
    input  wire logic  ref_ok,
    input  wire logic  sample_tick,
    input  wire logic  fault_clear,
    output logic       calibrating,
    output logic       low_ref_valid_flag,
    output logic       low_ref_invalid_flag,
    output logic       high_ref_valid_flag,
    output logic       high_ref_invalid_flag,
    output logic       cal_done_flag,
    output logic       cal_fault_flag
);
    import aicsr_pkg::*;
    aicsr_cal_state_t state, next_state;
    logic [9:0] hold, next_hold;
    logic req_q, low_q, high_q;
    logic next_lv, next_li, next_hv, next_hi, next_fault;
    logic low_edge, high_edge, start;

    assign low_edge    = low_point_sample_request && !low_q;
    assign high_edge   = high_req && !high_q;
    assign start       = cal_req && !req_q;
    assign calibrating   = (state == CAL_RUN);
    assign cal_done_flag = (state == CAL_HOLD);

    // ======================================================
    // Calibration sequence, reference flags and fault.
    always_comb
    begin
        next_state = state;
        next_hold  = hold;
        next_lv    = low_ref_valid_flag;
        next_li    = low_ref_invalid_flag;
        next_hv    = high_ref_valid_flag;
        next_hi    = high_ref_invalid_flag;
        next_fault = cal_fault_flag;
        // The clear goes first so that a fault raised in the same cycle survives it.
        if (fault_clear)
            next_fault = 1'b0;
        case (state)
            CAL_IDLE, CAL_HOLD:
            begin
                if (state == CAL_HOLD && sample_tick)
                begin
                    next_hold = hold + 10'h1;
                    if (hold == 10'(`AICSR_HOLD_SAMPLES - 1))
                        next_state = CAL_IDLE;
                end
                if (start)
                begin
                    next_state = CAL_RUN;
                    {next_lv, next_li, next_hv, next_hi} = 4'h0;
                end
            end
            CAL_RUN:
            begin
                if (!cal_req)
                begin
                    // An early drop is a failed calibration.
                    next_state = CAL_IDLE;
                    next_fault = 1'b1;
                end
                else if (low_ref_valid_flag && high_ref_valid_flag)
                begin
                    next_state = CAL_HOLD;
                    next_hold  = 10'h0;
                    next_fault = 1'b0;
                end
                else
                begin
                    if (low_edge)
                    begin
                        next_lv = ref_ok;
                        next_li = !ref_ok;
                    end
                    if (high_edge)
                    begin
                        next_hv = ref_ok;
                        next_hi = !ref_ok;
                    end
                end
            end
            default:
                next_state = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= CAL_IDLE;
            hold  <= 10'h0;
            {req_q, low_q, high_q} <= 3'h0;
            {low_ref_valid_flag, low_ref_invalid_flag} <= 2'h0;
            {high_ref_valid_flag, high_ref_invalid_flag} <= 2'h0;
            cal_fault_flag <= 1'b0;
        end
        else
        begin
            state <= next_state;
            hold  <= next_hold;
            {req_q, low_q, high_q} <= {cal_req, low_point_sample_request, high_req};
            {low_ref_valid_flag, low_ref_invalid_flag} <= {next_lv, next_li};
            {high_ref_valid_flag, high_ref_invalid_flag} <= {next_hv, next_hi};
            cal_fault_flag <= next_fault;
        end
    end

    sequence s_aborted;
        calibrating && !cal_req;
    endsequence
    property p_abort_fault;
        @(posedge clk) disable iff (!reset_n)
        s_aborted |=> cal_fault_flag && !calibrating;
    endproperty
    a_abort_fault: assert property (p_abort_fault)
        else $error("Aborted calibration left no fault.");
    property p_low_sample;
        @(posedge clk) disable iff (!reset_n)
        calibrating && cal_req && low_edge && !high_ref_valid_flag
        |=> low_ref_valid_flag == $past(ref_ok) && low_ref_invalid_flag != $past(ref_ok);
    endproperty
    a_low_sample: assert property (p_low_sample)
        else $error("Low reference not sampled on request edge.");
    property p_success;
        @(posedge clk) disable iff (!reset_n)
        calibrating && cal_req && low_ref_valid_flag && high_ref_valid_flag
        |=> cal_done_flag && !calibrating && !cal_fault_flag;
    endproperty
    a_success: assert property (p_success)
        else $error("Success flag not raised after both references.");
    property p_hold_len;
        @(posedge clk) disable iff (!reset_n)
        $fell(cal_done_flag) && !calibrating
        |-> $past(hold) == 10'(`AICSR_HOLD_SAMPLES - 1);
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("Success flag held for the wrong sample count.");
    property p_start_clear;
        @(posedge clk) disable iff (!reset_n)
        !calibrating && start |=> calibrating && !low_ref_valid_flag && !high_ref_invalid_flag;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("Reference flags not cleared at calibration start.");
endmodule : aicsr_cal_chan

/* File: aicsr_fe_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Front end model: one frame of eight samples after each start pulse.
module aicsr_fe_model (
    input  wire logic                clk,
    input  wire logic                start,
    input  wire logic signed [31:0]  level,
    output logic                     sample_valid,
    output logic [2:0]               sample_chan,
    output logic signed [31:0]       sample_raw
);
    logic [3:0] left = 4'h0;
    // Channels leave in order, one per cycle, channel 7 closing the frame.
    always_ff @(posedge clk)
    begin
        if (start)
            left <= 4'h8;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    // Outside a frame the data bus carries the inverse, so stale values cannot pass.
    assign sample_valid = (left != 4'h0);
    assign sample_chan  = 3'(4'h8 - left);
    assign sample_raw   = sample_valid ? level : ~level;
endmodule : aicsr_fe_model

/* File: aicsr_ms_timer.sv */
`timescale 1ns/1ps
`include "aicsr_params.svh"
module aicsr_ms_timer #(
    parameter int MS_CYCLES = `AICSR_MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    output logic [15:0]      wrapping_ms_count
);
    import aicsr_pkg::*;
    logic [31:0] div;
    logic [31:0] next_div;
    logic [15:0] next_cnt;

    // ======================================================
    // Millisecond divider and wrapping count.
    always_comb
    begin
        next_div = div + 32'h1;
        next_cnt = wrapping_ms_count;
        if (div == 32'(MS_CYCLES - 1))
        begin
            next_div = 32'h0;
            next_cnt = (wrapping_ms_count == `AICSR_ROLL_MAX) ? 16'h0
                     : wrapping_ms_count + 16'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div               <= 32'h0;
            wrapping_ms_count <= 16'h0;
        end
        else
        begin
            div               <= next_div;
            wrapping_ms_count <= next_cnt;
        end
    end

    property p_roll_wrap;
        @(posedge clk) disable iff (!reset_n)
        (div == 32'(MS_CYCLES - 1)) |=> (wrapping_ms_count ==
            (($past(wrapping_ms_count) == `AICSR_ROLL_MAX) ? 16'h0
             : $past(wrapping_ms_count) + 16'h1));
    endproperty
    a_roll_wrap: assert property (p_roll_wrap)
        else $error("Rolling count did not step or wrap.");
endmodule : aicsr_ms_timer

/* File: aicsr_params.svh */
`ifndef AICSR_PARAMS_SVH
`define AICSR_PARAMS_SVH
// ==========================================================
// Channel count and register field layout.
`define AICSR_NCH        8
`define AICSR_FLD        8
`define AICSR_F0         0
`define AICSR_F1         8
`define AICSR_F2         16
`define AICSR_F3         24
`define AICSR_BANK_LSB   5
`define AICSR_IDX_LSB    2
`define AICSR_GAIN_FRAC  16
// ==========================================================
// Register offsets.
`define AICSR_A_CTRL     8'h00
`define AICSR_A_CALST    8'h04
`define AICSR_A_REFST    8'h08
`define AICSR_A_ISTAT    8'h0c
`define AICSR_A_IMASK    8'h10
`define AICSR_A_RSCALE   8'h14
`define AICSR_A_TS_LO    8'h18
`define AICSR_A_TS_HI    8'h1c
`define AICSR_A_ROLL     8'h20
`define AICSR_B_GAIN     3'h2
`define AICSR_B_OFFSET   3'h3
`define AICSR_B_DATA     3'h4
`define AICSR_B_RATE     3'h5
// ==========================================================
// Interrupt status layout and reset values.
`define AICSR_IRQ_W      17
`define AICSR_IRQ_FRAME  16
`define AICSR_GAIN_RST   32'h0001_0000
`define AICSR_RSCALE_RST 32'h0000_0001
// ==========================================================
// Timing.
`define AICSR_CLK_NS       50
`define AICSR_MS_NS        1000000
`define AICSR_MS_CYCLES    (`AICSR_MS_NS / `AICSR_CLK_NS)
`define AICSR_ROLL_MAX     16'h7fff
`define AICSR_HOLD_SAMPLES 1000
`endif

/* File: aicsr_pkg.sv */
package aicsr_pkg;
    typedef logic [31:0]        aicsr_word_t;
    typedef logic signed [31:0] aicsr_sword_t;
    typedef logic [2:0]         aicsr_chan_t;
    typedef logic [7:0]         aicsr_addr_t;
    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_HOLD = 2'b10
    } aicsr_cal_state_t;
endpackage : aicsr_pkg

/* File: aicsr_readout.sv */
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "aicsr_params.svh"
// Functional notes
// - Valid low reference sets its valid flag
// - Invalid low reference sets its invalid flag
// - Abort with bad low ref sets fault
// - Valid high reference sets its valid flag
// - Invalid high reference sets its invalid flag
// - Abort with bad high ref sets fault
// - Success flag when calibration completes
// - Success flag held for 1000 samples
// - Report value change per second
// - Rate is zero by default and unchanged
// - Value scaled per channel, signed
// - Capture 64-bit frame timestamp, two words
// - Millisecond rolling count wraps after 32767
// - Early calibrate drop stops and faults
// - Low reference sampled on request edge
// - Calibrating flag while calibration runs
module aicsr_readout #(
    parameter int MS_CYCLES = `AICSR_MS_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire aicsr_pkg::aicsr_addr_t addr,
    input  wire aicsr_pkg::aicsr_word_t wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output aicsr_pkg::aicsr_word_t      rdata,
    output logic                        irq,
    input  wire logic                   sample_valid,
    input  wire aicsr_pkg::aicsr_chan_t sample_chan,
    input  wire aicsr_pkg::aicsr_sword_t sample_raw,
    input  wire logic [63:0]            sync_time,
    input  wire logic [7:0]             ref_ok,
    input  wire logic                   hot_reinsertion_event
);
    import aicsr_pkg::*;

    // ======================================================
    // Software visible control and configuration.
    aicsr_word_t  ctrl, next_ctrl;
    aicsr_word_t  mask, next_mask;
    aicsr_word_t  rate_scale, next_rate_scale;
    aicsr_sword_t gain [`AICSR_NCH];
    aicsr_sword_t offset [`AICSR_NCH];
    aicsr_sword_t next_gain [`AICSR_NCH];
    aicsr_sword_t next_offset [`AICSR_NCH];
    logic [`AICSR_IRQ_W-1:0] istat, next_istat;
    aicsr_word_t  next_rdata;

    // ======================================================
    // Sample path state.
    aicsr_sword_t pend_value [`AICSR_NCH];
    aicsr_sword_t pend_rate [`AICSR_NCH];
    aicsr_sword_t data_out [`AICSR_NCH];
    aicsr_sword_t rate_out [`AICSR_NCH];
    aicsr_sword_t next_pend_value [`AICSR_NCH];
    aicsr_sword_t next_pend_rate [`AICSR_NCH];
    aicsr_sword_t next_data_out [`AICSR_NCH];
    aicsr_sword_t next_rate_out [`AICSR_NCH];
    logic [`AICSR_NCH-1:0] seen, next_seen;
    logic [63:0]  ts, next_ts;
    logic [15:0]  roll, next_roll;
    logic [15:0]  ms_count;
    logic signed [63:0] gain_prod;
    logic signed [63:0] rate_prod;
    aicsr_sword_t scaled;
    aicsr_sword_t delta;
    logic         frame_end;

    // ======================================================
    // Per-channel calibration flags.
    logic [`AICSR_NCH-1:0] calibrating, lv, li, hv, hi, done, fault;
    logic [`AICSR_NCH-1:0] done_q, fault_q;
    logic [`AICSR_NCH-1:0] tick;

    logic [2:0]  bank;
    logic [2:0]  idx;
    assign bank = addr[`AICSR_BANK_LSB +: 3];
    assign idx  = addr[`AICSR_IDX_LSB +: 3];

    // ======================================================
    // Millisecond rolling count.
    aicsr_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .clk               (clk),
        .reset_n           (reset_n),
        .wrapping_ms_count (ms_count)
    );

    // ======================================================
    // One calibration sequencer per channel.
    for (genvar c = 0; c < `AICSR_NCH; c++)
    begin : g_cal
        assign tick[c] = sample_valid && (sample_chan == 3'(c));
        aicsr_cal_chan u_cal (
            .clk                      (clk),
            .reset_n                  (reset_n),
            .cal_req                  (ctrl[`AICSR_F0 + c]),
            .low_point_sample_request (ctrl[`AICSR_F1 + c]),
            .high_req                 (ctrl[`AICSR_F2 + c]),
            .ref_ok                   (ref_ok[c]),
            .sample_tick              (tick[c]),
            .fault_clear              (hot_reinsertion_event),
            .calibrating              (calibrating[c]),
            .low_ref_valid_flag       (lv[c]),
            .low_ref_invalid_flag     (li[c]),
            .high_ref_valid_flag      (hv[c]),
            .high_ref_invalid_flag    (hi[c]),
            .cal_done_flag            (done[c]),
            .cal_fault_flag           (fault[c])
        );
    end

    // ======================================================
    // Scaling and rate arithmetic for the arriving sample.
    // The rate assumes a constant sample period: software loads
    // the sample rate per second, so no divider is needed.
    assign gain_prod = 64'(sample_raw) * 64'(gain[sample_chan]);
    assign scaled    = gain_prod[`AICSR_GAIN_FRAC +: 32]
                     + offset[sample_chan];
    assign delta     = scaled - pend_value[sample_chan];
    assign rate_prod = 64'(delta) * 64'($signed(rate_scale));
    assign frame_end = sample_valid && (sample_chan == 3'(`AICSR_NCH - 1));

    always_comb
    begin
        next_pend_value = pend_value;
        next_pend_rate  = pend_rate;
        next_data_out   = data_out;
        next_rate_out   = rate_out;
        next_seen       = seen;
        next_ts         = ts;
        next_roll       = roll;
        if (sample_valid)
        begin
            next_pend_value[sample_chan] = scaled;
            // First sample has no predecessor, so it reads as no change.
            next_pend_rate[sample_chan]  = seen[sample_chan]
                                         ? rate_prod[31:0] : 32'sh0;
            next_seen[sample_chan]       = 1'b1;
        end
        if (frame_end)
        begin
            // The whole set moves at once so reads never mix frames.
            next_data_out = next_pend_value;
            next_rate_out = next_pend_rate;
            next_ts       = sync_time;
            next_roll     = ms_count;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < `AICSR_NCH; i++)
            begin
                pend_value[i] <= 32'sh0;
                pend_rate[i]  <= 32'sh0;
                data_out[i]   <= 32'sh0;
                rate_out[i]   <= 32'sh0;
            end
            seen <= 8'h0;
            ts   <= 64'h0;
            roll <= 16'h0;
        end
        else
        begin
            pend_value <= next_pend_value;
            pend_rate  <= next_pend_rate;
            data_out   <= next_data_out;
            rate_out   <= next_rate_out;
            seen       <= next_seen;
            ts         <= next_ts;
            roll       <= next_roll;
        end
    end

    // ======================================================
    // Register writes, interrupt status and read data.
    always_comb
    begin
        next_ctrl       = ctrl;
        next_mask       = mask;
        next_rate_scale = rate_scale;
        next_gain       = gain;
        next_offset     = offset;
        next_istat      = istat;
        next_rdata      = 32'h0;
        if (wr)
        begin
            case (addr)
                `AICSR_A_CTRL:   next_ctrl = wdata;
                `AICSR_A_ISTAT:  next_istat = istat & ~wdata[`AICSR_IRQ_W-1:0];
                `AICSR_A_IMASK:  next_mask = wdata;
                `AICSR_A_RSCALE: next_rate_scale = wdata;
                default:
                begin
                    if (bank == `AICSR_B_GAIN)
                        next_gain[idx] = wdata;
                    else if (bank == `AICSR_B_OFFSET)
                        next_offset[idx] = wdata;
                end
            endcase
        end
        // Events are applied after the clear so a set in the same cycle wins.
        next_istat[`AICSR_F0 +: `AICSR_FLD] = next_istat[`AICSR_F0 +: `AICSR_FLD]
                                           | (done & ~done_q);
        next_istat[`AICSR_F1 +: `AICSR_FLD] = next_istat[`AICSR_F1 +: `AICSR_FLD]
                                           | (fault & ~fault_q);
        next_istat[`AICSR_IRQ_FRAME] = next_istat[`AICSR_IRQ_FRAME] | frame_end;
        if (rd)
        begin
            case (addr)
                `AICSR_A_CTRL:   next_rdata = ctrl;
                `AICSR_A_CALST:  next_rdata = {8'h0, fault, done, calibrating};
                `AICSR_A_REFST:  next_rdata = {hi, hv, li, lv};
                `AICSR_A_ISTAT:  next_rdata = 32'(istat);
                `AICSR_A_IMASK:  next_rdata = mask;
                `AICSR_A_RSCALE: next_rdata = rate_scale;
                `AICSR_A_TS_LO:  next_rdata = ts[31:0];
                `AICSR_A_TS_HI:  next_rdata = ts[63:32];
                `AICSR_A_ROLL:   next_rdata = 32'(roll);
                default:
                begin
                    case (bank)
                        `AICSR_B_GAIN:   next_rdata = gain[idx];
                        `AICSR_B_OFFSET: next_rdata = offset[idx];
                        `AICSR_B_DATA:   next_rdata = data_out[idx];
                        `AICSR_B_RATE:   next_rdata = rate_out[idx];
                        default:         next_rdata = 32'h0;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl       <= 32'h0;
            mask       <= 32'h0;
            rate_scale <= `AICSR_RSCALE_RST;
            for (int i = 0; i < `AICSR_NCH; i++)
            begin
                gain[i]   <= `AICSR_GAIN_RST;
                offset[i] <= 32'sh0;
            end
            istat   <= 17'h0;
            rdata   <= 32'h0;
            done_q  <= 8'h0;
            fault_q <= 8'h0;
        end
        else
        begin
            ctrl       <= next_ctrl;
            mask       <= next_mask;
            rate_scale <= next_rate_scale;
            gain       <= next_gain;
            offset     <= next_offset;
            istat      <= next_istat;
            rdata      <= next_rdata;
            done_q     <= done;
            fault_q    <= fault;
        end
    end

    // Level interrupt while any unmasked status bit is set.
    assign irq = |(istat & mask[`AICSR_IRQ_W-1:0]);

    // ======================================================
    // Checks.
    property p_value_capture;
        @(posedge clk) disable iff (!reset_n)
        sample_valid |=> pend_value[$past(sample_chan)] == $past(scaled);
    endproperty
    a_value_capture: assert property (p_value_capture)
        else $error("Scaled value not captured.");

    property p_rate_zero;
        @(posedge clk) disable iff (!reset_n)
        sample_valid && (!seen[sample_chan] || scaled == pend_value[sample_chan])
        |=> pend_rate[$past(sample_chan)] == 32'sh0;
    endproperty
    a_rate_zero: assert property (p_rate_zero)
        else $error("Rate not zero for unchanged value.");

    property p_rate_calc;
        @(posedge clk) disable iff (!reset_n)
        sample_valid && seen[sample_chan]
        |=> pend_rate[$past(sample_chan)] == $past(rate_prod[31:0]);
    endproperty
    a_rate_calc: assert property (p_rate_calc)
        else $error("Rate of change mismatch.");

    sequence s_frame_commit;
        ##1 ts == $past(sync_time) && roll == $past(ms_count);
    endsequence
    property p_frame_commit;
        @(posedge clk) disable iff (!reset_n)
        frame_end |-> s_frame_commit ##0 data_out[`AICSR_NCH-1] == $past(scaled);
    endproperty
    a_frame_commit: assert property (p_frame_commit)
        else $error("Frame set did not commit together.");

    property p_ts_hold;
        @(posedge clk) disable iff (!reset_n)
        !frame_end |=> ts == $past(ts) && roll == $past(roll);
    endproperty
    a_ts_hold: assert property (p_ts_hold)
        else $error("Timestamp moved outside a frame end.");
endmodule : aicsr_readout

/* File: tb.sv */
`timescale 1ns/1ps
`include "aicsr_params.svh"
// ==========================================================
// Self-checking bench for the calibration status readout.
module tb;
    import aicsr_pkg::*;
    logic         clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic         start = 1'b0, hot = 1'b0, irq, sv;
    aicsr_addr_t  addr = 8'h00;
    aicsr_word_t  wdata = 32'h0, rdata;
    aicsr_chan_t  sc;
    aicsr_sword_t sr, lvl = 32'sh0;
    logic [63:0]  sync_time = 64'h0123_4567_89ab_cdef;
    logic [7:0]   ref_ok = 8'h01;
    int           err_count = 0, n_checks = 0;
    localparam int MS = 4;
    int           cyc = 0;
    logic [15:0]  exp_roll = 16'h0;
    // Half period of 25 ns gives the 50 ns clock.
    always #25 clk = ~clk;
    // Millisecond count expected at each channel 7 sample, counted from reset release.
    always @(posedge clk)
    begin
        if (reset_n)
        begin
            cyc <= cyc + 1;
            if (sv && sc == 3'h7)
                exp_roll <= 16'((cyc / MS) % (`AICSR_ROLL_MAX + 1));
        end
    end
    aicsr_fe_model fe_u (.clk(clk), .start(start), .level(lvl), .sample_valid(sv),
        .sample_chan(sc), .sample_raw(sr));
    // A short millisecond keeps the rolling count moving in a short run.
    aicsr_readout #(.MS_CYCLES(MS)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sample_valid(sv),
        .sample_chan(sc), .sample_raw(sr), .sync_time(sync_time), .ref_ok(ref_ok),
        .hot_reinsertion_event(hot));
    task automatic chk(input string what, input aicsr_word_t seen, input aicsr_word_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // The extra edge keeps back-to-back writes from touching the strobe twice at once.
    task automatic wr_reg(input aicsr_addr_t a, input aicsr_word_t d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input aicsr_addr_t a, input aicsr_word_t exp, input string what);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, rdata, exp);
        @(posedge clk);
    endtask : rd_reg
    task automatic frame(input aicsr_sword_t v);
        lvl <= v;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : frame
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #2000000;
        err_count++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_reg(8'h40, 32'h0001_0000, "gain0");
        rd_reg(`AICSR_A_RSCALE, 32'h1, "rscale");
        rd_reg(`AICSR_A_CALST, 32'h0, "calst");
        wr_reg(8'h60, 32'hffff_fffb);
        wr_reg(`AICSR_A_IMASK, 32'h1_0000);
        wr_reg(8'h44, 32'h0002_0000);
        frame(32'sd100);
        chk("irq", {31'h0, irq}, 32'h1);
        rd_reg(8'h80, 32'h5f, "data0");
        rd_reg(8'ha0, 32'h0, "rate0");
        rd_reg(`AICSR_A_TS_LO, 32'h89ab_cdef, "ts_lo");
        rd_reg(`AICSR_A_TS_HI, 32'h0123_4567, "ts_hi");
        rd_reg(8'h84, 32'hc8, "data1");
        rd_reg(`AICSR_A_ROLL, 32'(exp_roll), "roll");
        wr_reg(`AICSR_A_ISTAT, 32'h1_0000);
        chk("irq", {31'h0, irq}, 32'h0);
        wr_reg(`AICSR_A_RSCALE, 32'h2);
        frame(32'sd130);
        rd_reg(8'h80, 32'h7d, "data0");
        rd_reg(8'ha0, 32'h3c, "rate0");
        // Channel 0 calibrates with good references, calibrate held throughout.
        wr_reg(`AICSR_A_CTRL, 32'h1);
        rd_reg(`AICSR_A_CALST, 32'h1, "calst");
        wr_reg(`AICSR_A_CTRL, 32'h101);
        rd_reg(`AICSR_A_REFST, 32'h1, "refst");
        wr_reg(`AICSR_A_CTRL, 32'h1_0101);
        rd_reg(`AICSR_A_REFST, 32'h1_0001, "refst");
        rd_reg(`AICSR_A_CALST, 32'h100, "calst");
        // Channel 1 sees bad references, then the request drops early.
        wr_reg(`AICSR_A_CTRL, 32'h2);
        wr_reg(`AICSR_A_CTRL, 32'h202);
        wr_reg(`AICSR_A_CTRL, 32'h2_0202);
        rd_reg(`AICSR_A_REFST, 32'h0201_0201, "refst");
        wr_reg(`AICSR_A_CTRL, 32'h0);
        rd_reg(`AICSR_A_CALST, 32'h2_0100, "calst");
        rd_reg(`AICSR_A_ISTAT, 32'h1_0201, "istat");
        hot <= 1'b1;
        @(posedge clk);
        hot <= 1'b0;
        @(posedge clk);
        rd_reg(`AICSR_A_CALST, 32'h100, "calst");
        repeat (999) frame(32'sd130);
        rd_reg(`AICSR_A_CALST, 32'h100, "calst");
        repeat (2) frame(32'sd130);
        rd_reg(`AICSR_A_CALST, 32'h0, "calst");
        rd_reg(`AICSR_A_ROLL, 32'(exp_roll), "roll");
        rd_reg(8'ha0, 32'h0, "rate0");
        wr_reg(`AICSR_A_CTRL, 32'h1);
        rd_reg(`AICSR_A_REFST, 32'h0200_0200, "refst");
        give_verdict();
    end
endmodule : tb
